// File: hdl/tlic_map.svh
/*
 * Register offsets, bit positions, reset values, vectors and timing counts
 * for the two-level interrupt controller.
 * Assumes a 3-bit register address, 8-bit data and one instruction
 * cycle per clock.
 */
// Functional notes
// - two levels; high vectors to 000008h, low vectors to 000018h
// - an eligible high request preempts a low service routine
// - each source except ext pin zero has flag, enable and priority
// - bit 7 of reset control register switches two-level mode on
// - in two-level mode bit 7 enables high, bit 6 enables low sources
// - flag, enable and level enable all set vectors at once
// - taking an interrupt clears the governing global enable bit
// - taking pushes the return address, then loads the vector
// - return instruction sets the applicable global enable again
// - pin and port-change events reach the vector in 3 to 4 cycles
// - flags set on events whatever the enable bits say
// - main control bit 7 enables high level, bit 6 low level
// - timer zero overflow sets bit 2, enable bit 5, sticky
// - ext pin zero sets bit 1, enable bit 4, software clears
// - upper port pin change sets bit 0, enable bit 3, sticky
// - a lasting mismatch keeps setting the port-change flag
// - main control bits are read/write and reset to zero
// - single-level mode needs the peripheral group enable too
`ifndef TLIC_MAP_SVH
`define TLIC_MAP_SVH

// --------------------------------------------------------------------
// register offsets
// --------------------------------------------------------------------
`define TLIC_OFF_MAIN_CTRL 3'h0
`define TLIC_OFF_RESET_CTRL 3'h1
`define TLIC_OFF_PERIPH_FLAG 3'h2
`define TLIC_OFF_PERIPH_EN 3'h3
`define TLIC_OFF_PERIPH_PRIO 3'h4
`define TLIC_OFF_CORE_PRIO 3'h5
`define TLIC_OFF_UPPER_PORT 3'h6

// --------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------
`define TLIC_BIT_GLOBAL_HIGH 7
`define TLIC_BIT_GLOBAL_LOW 6
`define TLIC_BIT_T0_EN 5
`define TLIC_BIT_EXT0_EN 4
`define TLIC_BIT_PORT_EN 3
`define TLIC_BIT_T0_FLAG 2
`define TLIC_BIT_EXT0_FLAG 1
`define TLIC_BIT_PORT_FLAG 0
`define TLIC_BIT_PRIO_LEVELS 7
`define TLIC_BIT_CPRIO_T0 2
`define TLIC_BIT_CPRIO_PORT 0

// --------------------------------------------------------------------
// reset values, vectors, timing
// --------------------------------------------------------------------
`define TLIC_RST_MAIN_CTRL 8'h00
`define TLIC_RST_RESET_CTRL 8'h00
`define TLIC_RST_PERIPH 8'h00
`define TLIC_RST_PERIPH_PRIO 8'hff
`define TLIC_RST_CORE_PRIO 8'h05
`define TLIC_VEC_HIGH 21'h000008
`define TLIC_VEC_LOW 21'h000018
`define TLIC_EXT_LAT_MIN 3
`define TLIC_EXT_LAT_MAX 4

`endif

// File: hdl/tlic_pkg.sv
/*
 * Types shared by the interrupt controller modules.
 * Assumes the register bus carries 3-bit addresses and 8-bit data.
 */
package tlic_pkg;

	// ----------------------------------------------------------------
	// service nesting state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SVC_IDLE = 2'b00,
		SVC_LOW = 2'b01,
		SVC_HIGH = 2'b10,
		SVC_NEST = 2'b11
	} tlic_svc_t;

	// ----------------------------------------------------------------
	// register bus request
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} tlic_bus_req_t;

endpackage

// File: hdl/tlic_port_watch.sv
/*
 * Upper port change detector: keeps the pin value last read by software
 * and reports a mismatch while the pins differ from it.
 * Assumes pins synchronous to the clock.
 */
`timescale 1ns/1ps
`default_nettype none
module tlic_port_watch #(
	parameter int WIDTH = 4
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [WIDTH-1:0] i_pins,
	input wire logic i_port_read,
	output logic o_mismatch
);

	logic [WIDTH-1:0] latch_q;
	logic [WIDTH-1:0] diff;

	// -----------------------------------------------------------------
	// per-pin compare against the last read value
	// -----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : g_pin
			assign diff[g] = i_pins[g] ^ latch_q[g];
		end
	endgenerate

	// reading the port ends the mismatch
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			latch_q <= '0;
		end else if (i_port_read) begin
			latch_q <= i_pins;
		end
	end

	assign o_mismatch = |diff;

endmodule
`default_nettype wire

// File: hdl/tlic_top.sv
/*
 * Two-level prioritised interrupt controller: flags, enables, priority
 * bits, vector selection, return-address push and return handling.
 * Assumes one instruction cycle per clock and a core that accepts the
 * push strobe and the vector load whenever they are given.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tlic_map.svh"
module tlic_top
	import tlic_pkg::*;
#(
	parameter int NPER = 8,
	parameter int PC_W = 21
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire tlic_bus_req_t i_bus,
	output logic [7:0] o_rdata,
	input wire logic i_timer_zero_ovf,
	input wire logic i_ext_pin_zero,
	input wire logic [3:0] i_upper_port_pins,
	input wire logic [NPER-1:0] i_periph_evt,
	input wire logic i_return_from_irq_instr,
	input wire logic [PC_W-1:0] i_pc,
	output logic o_push_stb,
	output logic [PC_W-1:0] o_push_addr,
	output logic o_pc_load,
	output logic [PC_W-1:0] o_pc_vector,
	output logic o_high_level
);

	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	logic [7:0] main_ctrl_q;
	logic [7:0] reset_ctrl_q;
	logic [NPER-1:0] pflag_q;
	logic [NPER-1:0] pen_q;
	logic [NPER-1:0] pprio_q;
	logic [7:0] core_prio_q;
	logic ext_prev_q;
	logic load_pend_q;
	logic take_high_q;
	tlic_svc_t svc_q;
	logic mismatch;
	logic ext_edge;
	logic wr_main;
	logic priority_levels_enable;
	logic any_high;
	logic any_low;
	logic any_single;
	logic high_req;
	logic low_req;
	logic take;
	logic take_high;
	logic [NPER-1:0] pact;

	assign wr_main = i_bus.we && (i_bus.addr == `TLIC_OFF_MAIN_CTRL);
	assign priority_levels_enable = reset_ctrl_q[`TLIC_BIT_PRIO_LEVELS];
	assign ext_edge = i_ext_pin_zero && !ext_prev_q;

	// -----------------------------------------------------------------
	// upper port change detector
	// -----------------------------------------------------------------
	tlic_port_watch #(
		.WIDTH(4)
	) u_watch (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_pins(i_upper_port_pins),
		.i_port_read(i_bus.re && (i_bus.addr == `TLIC_OFF_UPPER_PORT)),
		.o_mismatch(mismatch)
	);

	// -----------------------------------------------------------------
	// request evaluation
	// -----------------------------------------------------------------
	// active sources: flag and enable both set
	assign pact = pflag_q & pen_q;

	// per-level requests; ext pin zero has no priority bit, always high
	always_comb begin
		logic t0;
		logic ex;
		logic pc;
		t0 = main_ctrl_q[`TLIC_BIT_T0_FLAG] && main_ctrl_q[`TLIC_BIT_T0_EN];
		ex = main_ctrl_q[`TLIC_BIT_EXT0_FLAG]
			&& main_ctrl_q[`TLIC_BIT_EXT0_EN];
		pc = main_ctrl_q[`TLIC_BIT_PORT_FLAG]
			&& main_ctrl_q[`TLIC_BIT_PORT_EN];
		any_high = ex || (t0 && core_prio_q[`TLIC_BIT_CPRIO_T0])
			|| (pc && core_prio_q[`TLIC_BIT_CPRIO_PORT])
			|| |(pact & pprio_q);
		any_low = (t0 && !core_prio_q[`TLIC_BIT_CPRIO_T0])
			|| (pc && !core_prio_q[`TLIC_BIT_CPRIO_PORT])
			|| |(pact & ~pprio_q);
		any_single = t0 || ex || pc
			|| (main_ctrl_q[`TLIC_BIT_GLOBAL_LOW] && |pact);
	end

	// level enables gate the requests
	always_comb begin
		if (priority_levels_enable) begin
			high_req = main_ctrl_q[`TLIC_BIT_GLOBAL_HIGH] && any_high;
			low_req = main_ctrl_q[`TLIC_BIT_GLOBAL_HIGH]
				&& main_ctrl_q[`TLIC_BIT_GLOBAL_LOW] && any_low;
		end else begin
			high_req = main_ctrl_q[`TLIC_BIT_GLOBAL_HIGH] && any_single;
			low_req = 1'b0;
		end
	end

	// a take waits only for a pending vector load to finish
	assign take = (high_req || low_req) && !load_pend_q;
	assign take_high = high_req;

	// -----------------------------------------------------------------
	// main control register
	// -----------------------------------------------------------------
	// flags: set wins over software clear; take clears only the governing global enable
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			main_ctrl_q <= `TLIC_RST_MAIN_CTRL;
		end else begin
			logic [7:0] nx;
			nx = main_ctrl_q;
			if (wr_main) begin
				nx = i_bus.wdata;
			end
			if (i_return_from_irq_instr) begin
				if (!priority_levels_enable || svc_q == SVC_HIGH || svc_q == SVC_NEST) begin
					nx[`TLIC_BIT_GLOBAL_HIGH] = 1'b1;
				end else if (svc_q == SVC_LOW) begin
					nx[`TLIC_BIT_GLOBAL_LOW] = 1'b1;
				end
			end
			if (take) begin
				if (!priority_levels_enable || take_high) begin
					nx[`TLIC_BIT_GLOBAL_HIGH] = 1'b0;
				end else begin
					nx[`TLIC_BIT_GLOBAL_LOW] = 1'b0;
				end
			end
			if (i_timer_zero_ovf) begin
				nx[`TLIC_BIT_T0_FLAG] = 1'b1;
			end
			if (ext_edge) begin
				nx[`TLIC_BIT_EXT0_FLAG] = 1'b1;
			end
			if (mismatch) begin
				nx[`TLIC_BIT_PORT_FLAG] = 1'b1;
			end
			main_ctrl_q <= nx;
		end
	end

	// -----------------------------------------------------------------
	// other software registers
	// -----------------------------------------------------------------
	// reset control, priority bits and peripheral enables
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			reset_ctrl_q <= `TLIC_RST_RESET_CTRL;
			core_prio_q <= `TLIC_RST_CORE_PRIO;
			pen_q <= NPER'(`TLIC_RST_PERIPH);
			pprio_q <= NPER'(`TLIC_RST_PERIPH_PRIO);
		end else if (i_bus.we) begin
			case (i_bus.addr)
				`TLIC_OFF_RESET_CTRL: begin
					reset_ctrl_q <= i_bus.wdata & 8'h80;
				end
				`TLIC_OFF_CORE_PRIO: begin
					core_prio_q <= i_bus.wdata & 8'h05;
				end
				`TLIC_OFF_PERIPH_EN: begin
					pen_q <= i_bus.wdata[NPER-1:0];
				end
				`TLIC_OFF_PERIPH_PRIO: begin
					pprio_q <= i_bus.wdata[NPER-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// peripheral flags: events set them in spite of a same-cycle clear
	genvar g;
	generate
		for (g = 0; g < NPER; g = g + 1) begin : g_pflag
			always_ff @(posedge i_clk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					pflag_q[g] <= 1'b0;
				end else if (i_periph_evt[g]) begin
					pflag_q[g] <= 1'b1;
				end else if (i_bus.we && i_bus.addr == `TLIC_OFF_PERIPH_FLAG) begin
					pflag_q[g] <= i_bus.wdata[g];
				end
			end
		end
	endgenerate

	// read data one cycle after the strobe, zero when unmapped
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata <= 8'h00;
		end else if (i_bus.re) begin
			case (i_bus.addr)
				`TLIC_OFF_MAIN_CTRL: o_rdata <= main_ctrl_q;
				`TLIC_OFF_RESET_CTRL: o_rdata <= reset_ctrl_q;
				`TLIC_OFF_PERIPH_FLAG: o_rdata <= 8'(pflag_q);
				`TLIC_OFF_PERIPH_EN: o_rdata <= 8'(pen_q);
				`TLIC_OFF_PERIPH_PRIO: o_rdata <= 8'(pprio_q);
				`TLIC_OFF_CORE_PRIO: o_rdata <= core_prio_q;
				`TLIC_OFF_UPPER_PORT: o_rdata <= {4'h0, i_upper_port_pins};
				default: o_rdata <= 8'h00;
			endcase
		end else begin
			o_rdata <= 8'h00;
		end
	end

	// -----------------------------------------------------------------
	// pin edge detect
	// -----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ext_prev_q <= 1'b0;
		end else begin
			ext_prev_q <= i_ext_pin_zero;
		end
	end

	// -----------------------------------------------------------------
	// take sequence: push first, vector load next cycle
	// -----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_push_stb <= 1'b0;
			o_push_addr <= '0;
			o_pc_load <= 1'b0;
			o_pc_vector <= '0;
			load_pend_q <= 1'b0;
			take_high_q <= 1'b0;
			o_high_level <= 1'b0;
		end else begin
			o_push_stb <= take;
			load_pend_q <= take;
			o_pc_load <= load_pend_q;
			if (take) begin
				o_push_addr <= i_pc;
				take_high_q <= take_high || !priority_levels_enable;
			end
			if (load_pend_q) begin
				o_pc_vector <= take_high_q ? PC_W'(`TLIC_VEC_HIGH)
					: PC_W'(`TLIC_VEC_LOW);
				o_high_level <= take_high_q;
			end
		end
	end

	// -----------------------------------------------------------------
	// service nesting tracker
	// -----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			svc_q <= SVC_IDLE;
		end else if (take) begin
			case (svc_q)
				SVC_IDLE: svc_q <= (take_high || !priority_levels_enable) ? SVC_HIGH : SVC_LOW;
				SVC_LOW: svc_q <= take_high ? SVC_NEST : SVC_LOW;
				default: svc_q <= svc_q;
			endcase
		end else if (i_return_from_irq_instr) begin
			case (svc_q)
				SVC_NEST: svc_q <= SVC_LOW;
				SVC_HIGH: svc_q <= SVC_IDLE;
				SVC_LOW: svc_q <= SVC_IDLE;
				default: svc_q <= SVC_IDLE;
			endcase
		end
	end

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	localparam int LAT_MIN = `TLIC_EXT_LAT_MIN, LAT_MAX = `TLIC_EXT_LAT_MAX;

	sequence s_push;
		o_push_stb && !o_pc_load;
	endsequence
	sequence s_load;
		o_pc_load && !o_push_stb;
	endsequence

	property p_vec_sel;
		o_pc_load |-> (o_pc_vector == (o_high_level ? `TLIC_VEC_HIGH
			: `TLIC_VEC_LOW));
	endproperty
	a_vec_sel: assert property (p_vec_sel) else $error("bad vector");

	property p_push_load;
		s_push |=> s_load;
	endproperty
	a_push_load: assert property (p_push_load) else $error("no load");

	property p_clear_low;
		(take && priority_levels_enable && !high_req) |=> !main_ctrl_q[`TLIC_BIT_GLOBAL_LOW];
	endproperty
	a_clear_low: assert property (p_clear_low) else $error("low kept");

	property p_high_first;
		(take && high_req && low_req) |=> ##1 (o_pc_vector == `TLIC_VEC_HIGH);
	endproperty
	a_high_first: assert property (p_high_first) else $error("low won");

	property p_t0_sticky;
		(main_ctrl_q[`TLIC_BIT_T0_FLAG] && !wr_main)
			|=> main_ctrl_q[`TLIC_BIT_T0_FLAG];
	endproperty
	a_t0_sticky: assert property (p_t0_sticky) else $error("flag lost");

	property p_flag_set;
		i_timer_zero_ovf |=> main_ctrl_q[`TLIC_BIT_T0_FLAG];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("no flag");

	property p_ret_low;
		(i_return_from_irq_instr && priority_levels_enable && svc_q == SVC_LOW && !take)
			|=> main_ctrl_q[`TLIC_BIT_GLOBAL_LOW];
	endproperty
	a_ret_low: assert property (p_ret_low) else $error("no reenable");

	property p_mismatch;
		mismatch |=> main_ctrl_q[`TLIC_BIT_PORT_FLAG];
	endproperty
	a_mismatch: assert property (p_mismatch) else $error("port flag");

	property p_preempt;
		(svc_q == SVC_LOW && high_req && !load_pend_q) |=> s_push ##1 s_load;
	endproperty
	a_preempt: assert property (p_preempt) else $error("no preempt");

	property p_ext_lat;
		(ext_edge && priority_levels_enable && main_ctrl_q[`TLIC_BIT_EXT0_EN]
			&& main_ctrl_q[`TLIC_BIT_GLOBAL_HIGH] && !load_pend_q
			&& !i_return_from_irq_instr && !wr_main && !take)
			|-> ##[LAT_MIN:LAT_MAX] o_pc_load;
	endproperty
	a_ext_lat: assert property (p_ext_lat) else $error("latency");

	property p_port_lat;
		(mismatch && !main_ctrl_q[`TLIC_BIT_PORT_FLAG] && priority_levels_enable && !take
			&& main_ctrl_q[`TLIC_BIT_PORT_EN] && !wr_main && !load_pend_q
			&& main_ctrl_q[`TLIC_BIT_GLOBAL_HIGH] && !i_return_from_irq_instr
			&& main_ctrl_q[`TLIC_BIT_GLOBAL_LOW])
			|-> ##[LAT_MIN:LAT_MAX] o_pc_load;
	endproperty
	a_port_lat: assert property (p_port_lat) else $error("port latency");
	property p_all_off;
		!main_ctrl_q[`TLIC_BIT_GLOBAL_HIGH] |-> !take;
	endproperty
	a_all_off: assert property (p_all_off) else $error("masked take");

endmodule
`default_nettype wire

// File: test/tlic_core_model.sv
/*
 * Behavioural model of the processor core that sits beside the interrupt
 * controller: program counter, return stack depth and return instruction.
 * Assumes one instruction cycle per clock and the controller's strobes.
 */
`timescale 1ns/1ps
`default_nettype none
module tlic_core_model #(
	parameter int PC_W = 21
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_push_stb,
	input wire logic i_pc_load,
	input wire logic [PC_W-1:0] i_pc_vector,
	input wire logic i_ret_req,
	output logic [PC_W-1:0] o_pc,
	output logic o_return,
	output logic [3:0] o_depth,
	output logic [3:0] o_order_err
);
	logic push_seen_q;

	// --------------------------------------------------------------
	// program counter
	// --------------------------------------------------------------
	// steps each instruction cycle, jumps on a vector load
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			o_pc <= '0;
		else if (i_pc_load)
			o_pc <= i_pc_vector;
		else
			o_pc <= o_pc + 1'b1;
	end

	// --------------------------------------------------------------
	// return stack and return instruction
	// --------------------------------------------------------------
	// a load must follow its push by exactly one cycle
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			push_seen_q <= 1'b0;
			o_depth <= '0;
			o_order_err <= '0;
			o_return <= 1'b0;
		end else begin
			push_seen_q <= i_push_stb;
			o_return <= i_ret_req;
			if (i_pc_load != push_seen_q)
				o_order_err <= o_order_err + 1'b1;
			if (i_push_stb && !o_return)
				o_depth <= o_depth + 1'b1;
			else if (o_return && !i_push_stb)
				o_depth <= o_depth - 1'b1;
		end
	end
endmodule
`default_nettype wire

// File: test/tb.sv
/*
 * Self-checking testbench for the two-level interrupt controller.
 * Assumes the register map header and a core model beside the design.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tlic_map.svh"
module tb import tlic_pkg::*;;
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	tlic_bus_req_t bus = '0;
	logic ovf = 1'b0;
	logic ext0 = 1'b0;
	logic [3:0] pins = 4'h0;
	logic [7:0] pevt = 8'h00;
	logic ret_req = 1'b0;
	logic [7:0] rdata;
	logic push_stb, pc_load, high_level, ret;
	logic [20:0] push_addr, pc_vec, pc;
	logic [3:0] depth, order_err;
	logic [20:0] pc_hist = '0;
	int fail_count = 0;
	int comparisons = 0;
	int cycles = 0;
	int n;

	tlic_top #(.NPER(8), .PC_W(21)) i_tlic_top (.i_clk(i_clk),
		.i_reset_n(i_reset_n), .i_bus(bus), .o_rdata(rdata),
		.i_timer_zero_ovf(ovf), .i_ext_pin_zero(ext0),
		.i_upper_port_pins(pins), .i_periph_evt(pevt),
		.i_return_from_irq_instr(ret), .i_pc(pc), .o_push_stb(push_stb),
		.o_push_addr(push_addr), .o_pc_load(pc_load),
		.o_pc_vector(pc_vec), .o_high_level(high_level));

	tlic_core_model #(.PC_W(21)) i_tlic_core_model (.i_clk(i_clk),
		.i_reset_n(i_reset_n), .i_push_stb(push_stb), .i_pc_load(pc_load),
		.i_pc_vector(pc_vec), .i_ret_req(ret_req), .o_pc(pc),
		.o_return(ret), .o_depth(depth), .o_order_err(order_err));

	// --------------------------------------------------------------
	// clock, pulse clearing, timeout
	// --------------------------------------------------------------
	always #4 i_clk = ~i_clk;

	// event strobes last one cycle
	always @(posedge i_clk) begin
		if (ovf)
			ovf <= 1'b0;
		if (pevt != 8'h00)
			pevt <= 8'h00;
		if (ret_req)
			ret_req <= 1'b0;
	end

	// core pc of the take cycle, held while push and load run
	always @(posedge i_clk) begin
		if (!push_stb && !pc_load)
			pc_hist <= pc;
	end

	// cuts a hang short
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fail_count++;
			print_verdict();
		end
	end

	// --------------------------------------------------------------
	// tasks
	// --------------------------------------------------------------
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(logic [2:0] a, logic [7:0] d);
		@(posedge i_clk);
		bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
		@(posedge i_clk);
		bus <= '0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(string what, logic [2:0] a, logic [7:0] exp);
		@(posedge i_clk);
		bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
		@(posedge i_clk);
		bus <= '0;
		#1;
		check(what, {24'h0, rdata}, {24'h0, exp});
	endtask

	// counts edges until a vector load, lim+1 when none comes
	task automatic wait_load(int lim);
		for (n = 1; n <= lim; n++) begin
			@(posedge i_clk);
			#1;
			if (pc_load === 1'b1)
				break;
		end
	endtask

	task automatic do_return();
		@(posedge i_clk);
		ret_req <= 1'b1;
		repeat (3) @(posedge i_clk);
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		repeat (20) @(posedge i_clk);
		i_reset_n <= 1'b1;
		// reset values, access kinds, unmapped place
		rd("main", `TLIC_OFF_MAIN_CTRL, 8'h00);
		rd("rstctl", `TLIC_OFF_RESET_CTRL, 8'h00);
		rd("coreprio", `TLIC_OFF_CORE_PRIO, 8'h05);
		rd("perprio", `TLIC_OFF_PERIPH_PRIO, 8'hff);
		wr(`TLIC_OFF_MAIN_CTRL, 8'h38);
		wr(3'h7, 8'hff);
		rd("main rw", `TLIC_OFF_MAIN_CTRL, 8'h38);
		rd("unmapped", 3'h7, 8'h00);
		wr(`TLIC_OFF_MAIN_CTRL, 8'h00);
		$display("test registers done");

		// flags set with every enable off
		@(posedge i_clk);
		ovf <= 1'b1;
		ext0 <= 1'b1;
		pins <= 4'h2;
		repeat (3) @(posedge i_clk);
		rd("poll flags", `TLIC_OFF_MAIN_CTRL, 8'h07);
		wr(`TLIC_OFF_MAIN_CTRL, 8'h00);
		rd("mismatch", `TLIC_OFF_MAIN_CTRL, 8'h01);
		rd("port", `TLIC_OFF_UPPER_PORT, 8'h02);
		wr(`TLIC_OFF_MAIN_CTRL, 8'h00);
		ext0 <= 1'b0;
		rd("cleared", `TLIC_OFF_MAIN_CTRL, 8'h00);
		check("no take", {28'h0, depth}, 32'h0);
		$display("test polling done");

		// single level: peripheral group enable gates peripherals
		wr(`TLIC_OFF_PERIPH_EN, 8'h01);
		wr(`TLIC_OFF_MAIN_CTRL, 8'h80);
		@(posedge i_clk);
		pevt <= 8'h01;
		wait_load(10);
		check("gated", n, 11);
		rd("pflag", `TLIC_OFF_PERIPH_FLAG, 8'h01);
		wr(`TLIC_OFF_MAIN_CTRL, 8'hc0);
		wait_load(10);
		check("single vec", {11'h0, pc_vec}, 32'h8);
		check("single push", {11'h0, push_addr}, {11'h0, pc_hist});
		rd("single ge", `TLIC_OFF_MAIN_CTRL, 8'h40);
		wr(`TLIC_OFF_PERIPH_FLAG, 8'h00);
		do_return();
		rd("single ret", `TLIC_OFF_MAIN_CTRL, 8'hc0);
		wr(`TLIC_OFF_MAIN_CTRL, 8'h00);
		wr(`TLIC_OFF_PERIPH_EN, 8'h00);
		$display("test single level done");

		// two levels: low take, high preempts, nested returns
		wr(`TLIC_OFF_RESET_CTRL, 8'h80);
		wr(`TLIC_OFF_CORE_PRIO, 8'h04);
		wr(`TLIC_OFF_PERIPH_PRIO, 8'h00);
		rd("perprio0", `TLIC_OFF_PERIPH_PRIO, 8'h00);
		wr(`TLIC_OFF_MAIN_CTRL, 8'he8);
		@(posedge i_clk);
		pins <= 4'h3;
		wait_load(10);
		check("latency", (n >= 3 && n <= 4), 1);
		check("low vec", {11'h0, pc_vec}, 32'h18);
		check("low push", {11'h0, push_addr}, {11'h0, pc_hist});
		check("low lvl", {31'h0, high_level}, 32'h0);
		rd("low ge", `TLIC_OFF_MAIN_CTRL, 8'ha9);
		@(posedge i_clk);
		ovf <= 1'b1;
		wait_load(10);
		check("preempt vec", {11'h0, pc_vec}, 32'h8);
		check("high push", {11'h0, push_addr}, {11'h0, pc_hist});
		check("high lvl", {31'h0, high_level}, 32'h1);
		check("depth", {28'h0, depth}, 32'h2);
		rd("high ge", `TLIC_OFF_MAIN_CTRL, 8'h2d);
		wr(`TLIC_OFF_MAIN_CTRL, 8'h28);
		rd("held", `TLIC_OFF_MAIN_CTRL, 8'h29);
		rd("port2", `TLIC_OFF_UPPER_PORT, 8'h03);
		wr(`TLIC_OFF_MAIN_CTRL, 8'h28);
		rd("clear", `TLIC_OFF_MAIN_CTRL, 8'h28);
		do_return();
		rd("ret high", `TLIC_OFF_MAIN_CTRL, 8'ha8);
		do_return();
		rd("ret low", `TLIC_OFF_MAIN_CTRL, 8'he8);
		check("depth0", {28'h0, depth}, 32'h0);
		check("order", {28'h0, order_err}, 32'h0);
		$display("test two levels done");

		// both levels eligible together, then a reset mid-run
		@(posedge i_clk);
		pins <= 4'h2;
		ovf <= 1'b1;
		wait_load(10);
		check("both vec", {11'h0, pc_vec}, 32'h8);
		check("both lvl", {31'h0, high_level}, 32'h1);
		repeat (3) @(posedge i_clk);
		#1;
		check("no low in high", {28'h0, depth}, 32'h1);
		@(posedge i_clk);
		i_reset_n <= 1'b0;
		pins <= 4'h0;
		repeat (3) @(posedge i_clk);
		#1;
		check("rst load", {31'h0, pc_load}, 32'h0);
		@(posedge i_clk);
		i_reset_n <= 1'b1;
		rd("rst main", `TLIC_OFF_MAIN_CTRL, 8'h00);
		$display("test priority and reset done");
		print_verdict();
	end
endmodule
`default_nettype wire
